//--- crm_bus_model.sv
// Behavioural model of the external bus logic that terminates cycles and feeds read data.
`timescale 1ns/100ps
module crm_bus_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic tip_oe_n,
   input wire logic tip_o,
   input wire logic [3:0] wait_cyc,
   input wire logic use_strobe,
   input wire logic use_err,
   input wire logic [31:0] rd_value,
   output logic ack_n,
   output logic err_n,
   output logic strobe_n,
   output logic [31:0] data
);
   logic [3:0] cnt;
   logic acked;
   logic busy;
   // A cycle runs while the in-progress pin is driven asserted.
   assign busy = !tip_oe_n && !tip_o;
   // ****************************************************************
   // Termination and read data
   // ****************************************************************
   // Counts wait states and terminates once; an idle data bus toggles so stale values never look valid.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cnt <= 4'h0;
         acked <= 1'b0;
         ack_n <= 1'b1;
         err_n <= 1'b1;
         strobe_n <= 1'b1;
         data <= 32'hA5A5A5A5;
      end else if (!busy || acked) begin
         cnt <= 4'h0;
         acked <= acked && busy;
         ack_n <= 1'b1;
         err_n <= 1'b1;
         strobe_n <= 1'b1;
         data <= ~data;
      end else if (cnt == wait_cyc) begin
         acked <= 1'b1;
         ack_n <= use_err;
         err_n <= !use_err;
         strobe_n <= !use_strobe;
         data <= use_strobe ? ~rd_value : rd_value;
      end else begin
         cnt <= cnt + 4'h1;
         strobe_n <= !(use_strobe && (cnt + 4'h1 < wait_cyc));
         data <= rd_value;
      end
   end
endmodule

//--- crm_pkg.sv
// Package with constants, types and the state record of the reset and mode select block.
package crm_pkg;

   // ****************************************************************
   // Timing counts and widths
   // ****************************************************************
   localparam int STRETCH_CYCLES = 128;   // Internal reset hold after the input negates.
   localparam int ROUT_CYCLES = 512;      // Reset output pulse length.
   localparam int DATA_W = 32;
   localparam int STRENGTH_W = 3;         // One strength bit per driver group.
   localparam int SCNT_W = 8;
   localparam int RCNT_W = 10;
   localparam logic [SCNT_W-1:0] STRETCH_LOAD = SCNT_W'(STRETCH_CYCLES - 1);
   localparam logic [RCNT_W-1:0] ROUT_LOAD = RCNT_W'(ROUT_CYCLES);

   // ****************************************************************
   // Register map on the APB
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
   localparam int CTRL_RESET_INSTR_BIT = 0;
   localparam int STAT_IN_RESET_BIT = 0;
   localparam int STAT_ROUT_BIT = 1;
   localparam int STAT_MUX_BIT = 2;
   localparam int STAT_STROBE_BIT = 3;
   localparam int STAT_STRENGTH_LSB = 4;
   localparam int STAT_MI_BIT = 7;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [6:0] {
      ST_HOLD = 7'h01,
      ST_DRAIN = 7'h02,
      ST_STRETCH = 7'h04,
      ST_WAITG = 7'h08,
      ST_IDLE = 7'h10,
      ST_C1 = 7'h20,
      ST_C2 = 7'h40
   } crm_state_type;

   // Three-state pin drive: level and active-low output enable.
   typedef struct packed {
      logic o;
      logic oe_n;
   } crm_pin_type;

   typedef struct packed {
      logic rst_meta;
      logic rst_sync;
      crm_state_type state;
      logic [SCNT_W-1:0] scnt;
      logic [RCNT_W-1:0] rcnt;
      logic rout_n;
      logic core_rst_n;
      logic mi_n;
      logic cyc_write;
      logic mux;
      logic strobe;
      logic [STRENGTH_W-1:0] strength;
      crm_pin_type bb;
      crm_pin_type transfer_in_progress_n;
      crm_pin_type ta;
      logic addr_oe_n;
      logic data_oe_n;
      logic cyc_done;
      logic [DATA_W-1:0] hold;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } crm_regs_type;

endpackage

//--- crm_reset_mode.sv
// Reset sequencer, reset-time mode selection and bus drive control with an APB register slave.
`timescale 1ns/100ps
module crm_reset_mode (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [crm_pkg::ADDR_W-1:0] PADDR,
   input wire logic [crm_pkg::DATA_W-1:0] PWDATA,
   output logic [crm_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RESET_IN_N,
   input wire logic CACHE_DISABLE_N,
   input wire logic MMU_DISABLE_N,
   input wire logic [crm_pkg::STRENGTH_W-1:0] INTERRUPT_LEVEL_PINS,
   input wire logic DATA_LATCH_STROBE_N,
   input wire logic [crm_pkg::DATA_W-1:0] DATA_IN,
   input wire logic BUS_GRANT_N,
   input wire logic TRANSFER_ACK_N_I,
   input wire logic TRANSFER_ERROR_ACK_N,
   input wire logic CORE_CYCLE_REQ,
   input wire logic CORE_CYCLE_WRITE,
   input wire logic SNOOP_ACK_DRIVE,
   output logic CORE_RESET_N,
   output logic RESET_OUT_N,
   output logic MEMORY_INHIBIT_N,
   output logic BUS_BUSY_N_O,
   output logic BUS_BUSY_N_OE_N,
   output logic TRANSFER_IN_PROGRESS_N_O,
   output logic TRANSFER_IN_PROGRESS_N_OE_N,
   output logic TRANSFER_ACK_N_O,
   output logic TRANSFER_ACK_N_OE_N,
   output logic ADDR_OE_N,
   output logic DATA_OE_N,
   output logic CYCLE_DONE,
   output logic [crm_pkg::DATA_W-1:0] READ_DATA,
   output logic MUX_BUS_MODE,
   output logic STROBE_MODE,
   output logic [crm_pkg::STRENGTH_W-1:0] DRIVE_STRENGTH
);

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************

   // Recognises a mapped register offset.
   function automatic logic addr_mapped(input logic [crm_pkg::ADDR_W-1:0] a);
      addr_mapped = (a == crm_pkg::CTRL_OFFSET) || (a == crm_pkg::STATUS_OFFSET);
   endfunction

   // True while a bus cycle of the device is running.
   function automatic logic in_cycle(input crm_pkg::crm_state_type s);
      in_cycle = (s == crm_pkg::ST_C1) || (s == crm_pkg::ST_C2);
   endfunction

   crm_pkg::crm_regs_type cur_ff;
   crm_pkg::crm_regs_type nxt_cur;
   logic [crm_pkg::DATA_W-1:0] latch_a;
   logic [crm_pkg::DATA_W-1:0] status_word;
   logic apb_write;

   // ****************************************************************
   // Read latch and status word
   // ****************************************************************

   // Latch A is open unless strobe mode is on and the strobe is asserted.
   always_comb begin
      if (cur_ff.strobe && !DATA_LATCH_STROBE_N) begin
         latch_a = cur_ff.hold;
      end else begin
         latch_a = DATA_IN;
      end
   end

   // Status word gathers the block's own state.
   always_comb begin
      status_word = '0;
      status_word[crm_pkg::STAT_IN_RESET_BIT] = !cur_ff.core_rst_n;
      status_word[crm_pkg::STAT_ROUT_BIT] = !cur_ff.rout_n;
      status_word[crm_pkg::STAT_MUX_BIT] = cur_ff.mux;
      status_word[crm_pkg::STAT_STROBE_BIT] = cur_ff.strobe;
      status_word[crm_pkg::STAT_STRENGTH_LSB +: crm_pkg::STRENGTH_W] = cur_ff.strength;
      status_word[crm_pkg::STAT_MI_BIT] = !cur_ff.mi_n;
   end

   // A write takes effect at the access edge where ready is high.
   assign apb_write = PSEL && PENABLE && PWRITE && cur_ff.pready && (PADDR == crm_pkg::CTRL_OFFSET);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // Reset sequence, bus cycle engine, reset output pulse and APB slave.
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.rst_meta = RESET_IN_N;
      nxt_cur.rst_sync = cur_ff.rst_meta;
      nxt_cur.cyc_done = 1'b0;
      nxt_cur.hold = latch_a;
      nxt_cur.bb = '{o: 1'b1, oe_n: 1'b1};
      nxt_cur.transfer_in_progress_n = '{o: 1'b1, oe_n: 1'b1};
      nxt_cur.ta = '{o: 1'b1, oe_n: 1'b1};
      nxt_cur.addr_oe_n = 1'b1;
      nxt_cur.data_oe_n = 1'b1;
      if (!cur_ff.rst_sync) begin
         // Input reset wins over everything, including a reset output pulse.
         nxt_cur.core_rst_n = 1'b0;
         nxt_cur.mi_n = 1'b0;
         nxt_cur.rout_n = 1'b1;
         nxt_cur.rcnt = '0;
         if (in_cycle(cur_ff.state) || (!cur_ff.ta.oe_n && !cur_ff.ta.o)) begin
            // Negate driven strobes for one cycle before floating them.
            nxt_cur.state = crm_pkg::ST_DRAIN;
            nxt_cur.cyc_done = in_cycle(cur_ff.state);
            nxt_cur.bb.oe_n = !in_cycle(cur_ff.state);
            nxt_cur.transfer_in_progress_n.oe_n = !in_cycle(cur_ff.state);
            nxt_cur.ta.oe_n = cur_ff.ta.oe_n;
         end else begin
            nxt_cur.state = crm_pkg::ST_HOLD;
         end
      end else begin
         case (cur_ff.state)
            crm_pkg::ST_HOLD: begin
               // First edge with the input seen negated: take the modes.
               nxt_cur.state = crm_pkg::ST_STRETCH;
               nxt_cur.scnt = crm_pkg::STRETCH_LOAD;
               nxt_cur.mux = !CACHE_DISABLE_N;
               nxt_cur.strobe = !MMU_DISABLE_N;
               nxt_cur.strength = INTERRUPT_LEVEL_PINS;
            end
            crm_pkg::ST_DRAIN: begin
               nxt_cur.state = crm_pkg::ST_HOLD;
            end
            crm_pkg::ST_STRETCH: begin
               if (cur_ff.scnt == '0) begin
                  nxt_cur.state = crm_pkg::ST_WAITG;
                  nxt_cur.core_rst_n = 1'b1;
               end else begin
                  nxt_cur.scnt = cur_ff.scnt - 1'b1;
               end
            end
            crm_pkg::ST_WAITG: begin
               // Bus floats until granted; the first cycle is the vector read.
               if (!BUS_GRANT_N) begin
                  nxt_cur.state = crm_pkg::ST_C1;
                  nxt_cur.cyc_write = 1'b0;
                  nxt_cur.mi_n = 1'b1;
               end
            end
            crm_pkg::ST_IDLE: begin
               if (!BUS_GRANT_N && CORE_CYCLE_REQ) begin
                  nxt_cur.state = crm_pkg::ST_C1;
                  nxt_cur.cyc_write = CORE_CYCLE_WRITE;
               end
            end
            crm_pkg::ST_C1: begin
               nxt_cur.state = crm_pkg::ST_C2;
            end
            crm_pkg::ST_C2: begin
               // Only the acknowledge inputs end the cycle, never the strobe.
               if (!TRANSFER_ACK_N_I || !TRANSFER_ERROR_ACK_N) begin
                  nxt_cur.state = crm_pkg::ST_IDLE;
                  nxt_cur.cyc_done = 1'b1;
                  if (!cur_ff.cyc_write) begin
                     nxt_cur.rdata = latch_a;
                  end
               end
            end
            default: begin
               nxt_cur.state = crm_pkg::ST_HOLD;
            end
         endcase
         // Bus drive follows the state the engine moves to; the acknowledge drive follows the snoop request outside core reset.
         if (in_cycle(nxt_cur.state)) begin
            nxt_cur.bb = '{o: 1'b0, oe_n: 1'b0};
            nxt_cur.transfer_in_progress_n = '{o: 1'b0, oe_n: 1'b0};
         end
         if (nxt_cur.state == crm_pkg::ST_C1) begin
            nxt_cur.addr_oe_n = 1'b0;
         end
         if (nxt_cur.state == crm_pkg::ST_C2) begin
            nxt_cur.addr_oe_n = nxt_cur.mux;
            nxt_cur.data_oe_n = !nxt_cur.cyc_write;
         end
         if (cur_ff.core_rst_n && SNOOP_ACK_DRIVE) begin
            nxt_cur.ta = '{o: 1'b0, oe_n: 1'b0};
         end
         // Reset output pulse; internal state is left alone.
         if (apb_write && PWDATA[crm_pkg::CTRL_RESET_INSTR_BIT] && cur_ff.core_rst_n && cur_ff.rout_n) begin
            nxt_cur.rcnt = crm_pkg::ROUT_LOAD;
         end else if (cur_ff.rcnt != '0) begin
            nxt_cur.rcnt = cur_ff.rcnt - 1'b1;
         end
         nxt_cur.rout_n = (nxt_cur.rcnt == '0);
      end
      // APB slave: data prepared in setup, ready in the first access cycle.
      nxt_cur.pready = PSEL && !PENABLE;
      nxt_cur.pslverr = PSEL && !PENABLE && !addr_mapped(PADDR);
      nxt_cur.prdata = '0;
      if (PSEL && !PENABLE && !PWRITE && (PADDR == crm_pkg::STATUS_OFFSET)) begin
         nxt_cur.prdata = status_word;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Synchronous reset puts the block into held reset with all pins floating.
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         cur_ff <= '{
            rst_meta: 1'b0, rst_sync: 1'b0, state: crm_pkg::ST_HOLD, scnt: '0, rcnt: '0,
            rout_n: 1'b1, core_rst_n: 1'b0, mi_n: 1'b0, cyc_write: 1'b0, mux: 1'b0,
            strobe: 1'b0, strength: '0, bb: '{o: 1'b1, oe_n: 1'b1}, transfer_in_progress_n: '{o: 1'b1, oe_n: 1'b1},
            ta: '{o: 1'b1, oe_n: 1'b1}, addr_oe_n: 1'b1, data_oe_n: 1'b1, cyc_done: 1'b0,
            hold: '0, rdata: '0, prdata: '0, pready: 1'b0, pslverr: 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Every output is a field of the state register.
   assign PRDATA = cur_ff.prdata;
   assign PREADY = cur_ff.pready;
   assign PSLVERR = cur_ff.pslverr;
   assign CORE_RESET_N = cur_ff.core_rst_n;
   assign RESET_OUT_N = cur_ff.rout_n;
   assign MEMORY_INHIBIT_N = cur_ff.mi_n;
   assign BUS_BUSY_N_O = cur_ff.bb.o;
   assign BUS_BUSY_N_OE_N = cur_ff.bb.oe_n;
   assign TRANSFER_IN_PROGRESS_N_O = cur_ff.transfer_in_progress_n.o;
   assign TRANSFER_IN_PROGRESS_N_OE_N = cur_ff.transfer_in_progress_n.oe_n;
   assign TRANSFER_ACK_N_O = cur_ff.ta.o;
   assign TRANSFER_ACK_N_OE_N = cur_ff.ta.oe_n;
   assign ADDR_OE_N = cur_ff.addr_oe_n;
   assign DATA_OE_N = cur_ff.data_oe_n;
   assign CYCLE_DONE = cur_ff.cyc_done;
   assign READ_DATA = cur_ff.rdata;
   assign MUX_BUS_MODE = cur_ff.mux;
   assign STROBE_MODE = cur_ff.strobe;
   assign DRIVE_STRENGTH = cur_ff.strength;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);

   // A reset hit on a running cycle, then one cycle of negated drive.
   sequence reset_hits_cycle;
      in_cycle(cur_ff.state) && !cur_ff.rst_sync;
   endsequence
   sequence drain_then_float;
      (!BUS_BUSY_N_OE_N && BUS_BUSY_N_O && !TRANSFER_IN_PROGRESS_N_OE_N && TRANSFER_IN_PROGRESS_N_O)
         ##1 (BUS_BUSY_N_OE_N && TRANSFER_IN_PROGRESS_N_OE_N);
   endsequence

   // Input reset reaches the core reset after the two-stage synchroniser.
   AST_SYNC_DELAY: assert property (!RESET_IN_N |-> ##3 !CORE_RESET_N)
      else $error("Input reset did not reach core reset in three clocks.");
   AST_MI_IN_RESET: assert property (!CORE_RESET_N |-> !MEMORY_INHIBIT_N)
      else $error("Memory inhibit negated during reset.");
   AST_STRETCH_LOAD: assert property ($rose(cur_ff.state == crm_pkg::ST_STRETCH) |-> cur_ff.scnt == crm_pkg::STRETCH_LOAD)
      else $error("Stretch counter loaded with the wrong count.");
   AST_STRETCH_END: assert property (
      cur_ff.state == crm_pkg::ST_STRETCH && cur_ff.scnt == '0 && cur_ff.rst_sync |=> CORE_RESET_N)
      else $error("Core reset not released at the end of the stretch.");
   AST_FLOAT_IN_HOLD: assert property (cur_ff.state == crm_pkg::ST_HOLD |->
      ADDR_OE_N && DATA_OE_N && BUS_BUSY_N_OE_N && TRANSFER_IN_PROGRESS_N_OE_N && TRANSFER_ACK_N_OE_N && RESET_OUT_N)
      else $error("An output is driven active while held in reset.");
   AST_GRANT_WAIT: assert property (cur_ff.state == crm_pkg::ST_WAITG |->
      BUS_BUSY_N_OE_N && ADDR_OE_N && !MEMORY_INHIBIT_N)
      else $error("Bus driven or inhibit released before the grant.");
   AST_FIRST_CYCLE: assert property (cur_ff.state == crm_pkg::ST_WAITG && !BUS_GRANT_N && cur_ff.rst_sync
      |=> !ADDR_OE_N && !BUS_BUSY_N_O && MEMORY_INHIBIT_N)
      else $error("First bus cycle did not start on the grant.");
   AST_MODE_HOLD: assert property (CORE_RESET_N && $past(CORE_RESET_N) |->
      $stable(MUX_BUS_MODE) && $stable(STROBE_MODE) && $stable(DRIVE_STRENGTH))
      else $error("Mode selection changed outside reset.");
   AST_MODE_CAPTURE: assert property (cur_ff.state == crm_pkg::ST_HOLD && cur_ff.rst_sync |=>
      MUX_BUS_MODE == !$past(CACHE_DISABLE_N) && STROBE_MODE == !$past(MMU_DISABLE_N)
      && DRIVE_STRENGTH == $past(INTERRUPT_LEVEL_PINS))
      else $error("Modes not taken from the pins at reset negation.");
   AST_DRAIN: assert property (reset_hits_cycle |=> drain_then_float)
      else $error("Busy and in-progress not negated before floating.");
   AST_ABORT_DONE: assert property (reset_hits_cycle |=> CYCLE_DONE)
      else $error("Reset did not terminate the running cycle.");
   AST_ROUT_LOAD: assert property ($fell(RESET_OUT_N) |-> cur_ff.rcnt == crm_pkg::ROUT_LOAD && CORE_RESET_N)
      else $error("Reset output pulse started with the wrong length.");
   AST_ROUT_END: assert property (cur_ff.rcnt == 10'h001 && cur_ff.rst_sync |=> RESET_OUT_N)
      else $error("Reset output did not end after its count.");
   AST_ROUT_ABORT: assert property (!cur_ff.rst_sync |=> RESET_OUT_N && !CORE_RESET_N)
      else $error("Input reset did not cancel the reset output.");
   AST_MUX_ADDR: assert property (cur_ff.state == crm_pkg::ST_C2 |-> ADDR_OE_N == MUX_BUS_MODE)
      else $error("Address drive wrong in the second bus clock.");
   AST_STROBE_HOLD: assert property (STROBE_MODE && !DATA_LATCH_STROBE_N && $past(!DATA_LATCH_STROBE_N)
      |-> $stable(cur_ff.hold))
      else $error("Held read value changed while the strobe was asserted.");

endmodule

//--- testbench.sv
// Self-checking testbench of the reset sequencer and mode select block.
`timescale 1ns/100ps
module testbench;
   logic CLOCK, RSTN, PSEL, PENABLE, PWRITE, RESET_IN_N, CACHE_DISABLE_N_N, MMU_DISABLE_N_N, GRANT_N, REQ, WR, SNOOP;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, DATA_IN, READ_DATA, rd_value, rd;
   logic PREADY, PSLVERR, STROBE_N, ACK_N, ERR_N, CORE_RESET_N, RESET_OUT_N, MI_N, BB_O, BB_OE_N;
   logic TIP_O, TIP_OE_N, TA_O, TA_OE_N, ADDR_OE_N, DATA_OE_N, CYCLE_DONE, MUX, SMODE, use_strobe, use_err, er;
   logic [2:0] IPL, STRENGTH;
   logic [3:0] wait_cyc;
   logic mux_exp, smode_exp;
   int fails, checked, seed, n;
   // ****************************************************************
   // Design, partner and clock
   // ****************************************************************
   crm_reset_mode u_dut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .RESET_IN_N(RESET_IN_N), .CACHE_DISABLE_N(CACHE_DISABLE_N_N), .MMU_DISABLE_N(MMU_DISABLE_N_N), .INTERRUPT_LEVEL_PINS(IPL),
      .DATA_LATCH_STROBE_N(STROBE_N), .DATA_IN(DATA_IN), .BUS_GRANT_N(GRANT_N),
      .TRANSFER_ACK_N_I(ACK_N & (TA_OE_N | TA_O)), .TRANSFER_ERROR_ACK_N(ERR_N), .CORE_CYCLE_REQ(REQ),
      .CORE_CYCLE_WRITE(WR), .SNOOP_ACK_DRIVE(SNOOP), .CORE_RESET_N(CORE_RESET_N), .RESET_OUT_N(RESET_OUT_N),
      .MEMORY_INHIBIT_N(MI_N), .BUS_BUSY_N_O(BB_O), .BUS_BUSY_N_OE_N(BB_OE_N), .TRANSFER_IN_PROGRESS_N_O(TIP_O),
      .TRANSFER_IN_PROGRESS_N_OE_N(TIP_OE_N), .TRANSFER_ACK_N_O(TA_O), .TRANSFER_ACK_N_OE_N(TA_OE_N),
      .ADDR_OE_N(ADDR_OE_N), .DATA_OE_N(DATA_OE_N), .CYCLE_DONE(CYCLE_DONE), .READ_DATA(READ_DATA),
      .MUX_BUS_MODE(MUX), .STROBE_MODE(SMODE), .DRIVE_STRENGTH(STRENGTH));
   crm_bus_model u_bus (.clock(CLOCK), .rstn(RSTN), .tip_oe_n(TIP_OE_N), .tip_o(TIP_O), .wait_cyc(wait_cyc),
      .use_strobe(use_strobe), .use_err(use_err), .rd_value(rd_value), .ack_n(ACK_N), .err_n(ERR_N),
      .strobe_n(STROBE_N), .data(DATA_IN));
   // The clock toggles every half period of 10 ns.
   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Compares one value and counts the outcome.
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("Counts: checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One APB transfer: setup, then access until PREADY is seen at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      k = 0;
      do begin
         @(posedge CLOCK);
         k++;
      end while (PREADY !== 1'b1 && k < 20);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (k >= 20) fails++;
   endtask
   // Holds the reset input low with random mode pins, releases it and checks the stretch and the modes.
   task automatic do_reset();
      logic [4:0] pins;
      pins = 5'($random(seed));
      @(posedge CLOCK);
      RESET_IN_N <= 1'b0;
      GRANT_N <= 1'b1;
      {CACHE_DISABLE_N_N, MMU_DISABLE_N_N, IPL} <= pins;
      repeat (12) @(posedge CLOCK);
      @(negedge CLOCK);
      check("held reset", {CORE_RESET_N, RESET_OUT_N, MI_N}, 32'h2);
      check("floating", {BB_OE_N, TIP_OE_N, TA_OE_N, ADDR_OE_N, DATA_OE_N}, 32'h1F);
      @(posedge CLOCK);
      RESET_IN_N <= 1'b1;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
         if (n == 5) {CACHE_DISABLE_N_N, MMU_DISABLE_N_N, IPL} <= 5'h1F;
      end while (CORE_RESET_N !== 1'b1 && n < 300);
      check("stretch", 32'(n > crm_pkg::STRETCH_CYCLES && n < crm_pkg::STRETCH_CYCLES + 6), 32'h1);
      mux_exp = !pins[4];
      smode_exp = !pins[3];
      check("modes", {MUX, SMODE, STRENGTH}, {mux_exp, smode_exp, pins[2:0]});
      repeat (4) begin
         @(negedge CLOCK);
         check("no grant", {TIP_OE_N, BB_OE_N, ADDR_OE_N, MI_N}, 32'hE);
      end
      @(posedge CLOCK);
      GRANT_N <= 1'b0;
   endtask
   // Runs one bus cycle, a write if w, with the partner terminating after 1 to 6 random wait states; cut_in resets it mid-cycle.
   task automatic run_cycle(input logic w, input logic cut_in);
      int k;
      @(posedge CLOCK);
      wait_cyc <= cut_in ? 4'hF : 4'(1 + $unsigned($random(seed)) % 6);
      use_strobe <= 1'($random(seed));
      use_err <= cut_in ? 1'b0 : 1'($random(seed));
      rd_value <= $random(seed);
      WR <= w;
      REQ <= 1'b1;
      k = 0;
      do begin
         @(negedge CLOCK);
         k++;
      end while ((TIP_OE_N !== 1'b0 || TIP_O !== 1'b0) && k < 40);
      check("first phase", {ADDR_OE_N, MI_N, BB_O}, 32'h2);
      @(posedge CLOCK);
      REQ <= 1'b0;
      if (cut_in) RESET_IN_N <= 1'b0;
      @(negedge CLOCK);
      check("second phase", {ADDR_OE_N, DATA_OE_N}, {mux_exp, !w});
      k = 1;
      while (CYCLE_DONE !== 1'b1 && k < 40) begin
         @(negedge CLOCK);
         k++;
      end
      if (cut_in) begin
         check("drain", {BB_OE_N, BB_O, TIP_OE_N, TIP_O, CORE_RESET_N}, 32'hA);
         @(negedge CLOCK);
         check("drained", {BB_OE_N, TIP_OE_N}, 32'h3);
      end else begin
         check("cycle length", k, 32'(wait_cyc) + 32'h2);
         if (!w && !use_err) check("read data", READ_DATA, (use_strobe && !smode_exp) ? ~rd_value : rd_value);
      end
   endtask
   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   // Stops a hung run as a failure.
   initial begin
      repeat (20000) @(posedge CLOCK);
      fails++;
      results();
   end
   // Resets, then walks random modes, bus cycles, reset pulses and APB corner cases.
   initial begin
      {RSTN, PSEL, PENABLE, PWRITE, REQ, WR, RESET_IN_N, use_strobe, use_err, SNOOP} = 10'h0;
      {CACHE_DISABLE_N_N, MMU_DISABLE_N_N, IPL, GRANT_N} = 6'h3F;
      {PADDR, PWDATA, rd_value, wait_cyc} = 76'h0;
      fails = 0;
      checked = 0;
      seed = 32'hCA3E;
      repeat (3) @(posedge CLOCK);
      RSTN <= 1'b1;
      repeat (4) begin
         do_reset();
         run_cycle(1'b0, 1'b0);
         repeat (4) run_cycle(1'($random(seed)), 1'b0);
         run_cycle(1'b0, 1'b1);
      end
      do_reset();
      apb(1'b0, 8'h08, 32'h0);
      check("unmapped", er, 32'h1);
      apb(1'b1, crm_pkg::CTRL_OFFSET, 32'h1);
      n = 0;
      do begin
         @(posedge CLOCK);
         n = n + 32'(RESET_OUT_N === 1'b0);
      end while (n == 0 || RESET_OUT_N === 1'b0 && n < 600);
      check("pulse length", n, crm_pkg::ROUT_CYCLES);
      check("core kept", {CORE_RESET_N, MUX, SMODE}, {1'b1, mux_exp, smode_exp});
      apb(1'b1, crm_pkg::CTRL_OFFSET, 32'h1);
      apb(1'b0, crm_pkg::STATUS_OFFSET, 32'h0);
      check("pulse status", rd[1:0], 32'h2);
      SNOOP <= 1'b1;
      RESET_IN_N <= 1'b0;
      repeat (2) @(negedge CLOCK);
      check("snoop ack", {TA_OE_N, TA_O}, 32'h0);
      repeat (2) @(negedge CLOCK);
      check("ack drain", {TA_OE_N, TA_O, RESET_OUT_N, CORE_RESET_N}, 32'h6);
      @(negedge CLOCK);
      check("ack float", {TA_OE_N, TA_O}, 32'h3);
      check("pulse cut", {RESET_OUT_N, CORE_RESET_N}, 32'h2);
      results();
   end
endmodule
